// ---- logic/nested_interrupt_acceptance.v ----
// Interrupt acceptance and nesting logic with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "nia_defs.vh"
module nested_interrupt_acceptance #(
  parameter NUM_REQ = 8,
  parameter IDX_W = 3
) (
  input wire hclk, // Bus and core clock
  input wire hresetn, // Asynchronous reset, active low
  input wire hsel, // Slave select
  input wire [31:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size, word only
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready in
  output wire hreadyout, // Slave ready out
  output wire hresp, // Always OKAY
  output reg [31:0] hrdata, // Read data
  input wire [NUM_REQ-1:0] req_in, // Peripheral request pins, rising edge
  input wire [`NM_COUNT-1:0] nm_in, // Non-maskable source pins, rising edge
  input wire instr_retire, // Core instruction boundary pulse
  input wire reti_valid, // Core return-from-handler pulse
  input wire [2:0] reti_level, // Restored processor level
  input wire reti_ien, // Restored enable flag
  output reg accept_valid, // Handler entry pulse
  output reg [5:0] accept_number, // Number of accepted interrupt
  output wire [2:0] processor_priority_level, // Current processor level
  output wire global_enable, // Current enable flag
  output wire irq // Level interrupt of status events
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg ien_reg, ien_next;
  reg [2:0] ipl_reg, ipl_next;
  reg first_block_reg;
  reg [15:0] user_stack_pointer, handler_stack_pointer;
  reg [NUM_REQ-1:0] req_s1_reg, req_s2_reg, req_s3_reg, pend_reg;
  reg [`NM_COUNT-1:0] nm_s1_reg, nm_s2_reg, nm_s3_reg, nm_pend_reg;
  reg [3*NUM_REQ-1:0] lvl_reg;
  reg [`EV_COUNT-1:0] stat_reg, en_reg;
  reg wr_pend_reg, rd_pend_reg, rd_done_reg;
  reg [7:0] addr_reg;
  reg [NUM_REQ-1:0] take_mask;
  reg [`NM_COUNT-1:0] nm_take;
  reg take_any, take_mask_ev;
  reg [5:0] take_num;
  reg [31:0] rd_mux;
  wire pick_found;
  wire [IDX_W-1:0] pick_idx;
  wire [2:0] pick_lvl;
  wire addr_ok;
  wire wr_fire, rd_fire, info_read;
  wire [7:0] req_ofs;
  wire [IDX_W-1:0] req_sel;
  wire req_hit;
  wire [`EV_COUNT-1:0] ev_set;

  assign processor_priority_level = ipl_reg;
  assign global_enable = ien_reg;
  assign hresp = 1'b0;
  assign irq = |(stat_reg & en_reg);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Reads take one wait state so the answer is a flop and sees prior writes
  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = ~(rd_pend_reg && !rd_done_reg);
  assign wr_fire = wr_pend_reg;
  assign rd_fire = rd_pend_reg && !rd_done_reg;
  assign info_read = rd_fire && (addr_reg == `OFS_INFO);
  assign req_ofs = addr_reg - `OFS_REQ_BASE;
  assign req_sel = req_ofs[IDX_W+1:2];
  assign req_hit = (addr_reg >= `OFS_REQ_BASE) && (req_ofs[7:2] < NUM_REQ);

  // Address phase capture and data phase sequencing
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_done_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else if (rd_fire)
      rd_done_reg <= 1'b1;
    else
    begin
      wr_pend_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      rd_done_reg <= 1'b0;
      if (addr_ok)
        addr_reg <= {haddr[7:2], 2'b00};
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (addr_reg)
      `OFS_INFO: rd_mux = {23'h000000, pick_lvl, {(6-IDX_W){1'b0}}, pick_idx};
      `OFS_CTRL: rd_mux = {25'h0000000, ipl_reg, 3'h0, ien_reg};
      `OFS_USP: rd_mux = {16'h0000, user_stack_pointer};
      `OFS_ISP: rd_mux = {16'h0000, handler_stack_pointer};
      `OFS_STAT: rd_mux = {29'h00000000, stat_reg};
      `OFS_EN: rd_mux = {29'h00000000, en_reg};
      default:
        if (req_hit)
          rd_mux = {28'h0000000, pend_reg[req_sel], lvl_reg[3*req_sel +: 3]};
    endcase
  end

  // Read data register
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_fire)
      hrdata <= rd_mux;
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_s1_reg <= {NUM_REQ{1'b0}};
      req_s2_reg <= {NUM_REQ{1'b0}};
      req_s3_reg <= {NUM_REQ{1'b0}};
      nm_s1_reg <= {`NM_COUNT{1'b0}};
      nm_s2_reg <= {`NM_COUNT{1'b0}};
      nm_s3_reg <= {`NM_COUNT{1'b0}};
    end
    else
    begin
      req_s1_reg <= req_in;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      nm_s1_reg <= nm_in;
      nm_s2_reg <= nm_s1_reg;
      nm_s3_reg <= nm_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Request selection and acceptance
  // ----------------------------------------------------------------
  // tie order by number
  request_pick #(
    .NUM_REQ(NUM_REQ),
    .IDX_W(IDX_W)
  ) u_pick (
    .pend(pend_reg),
    .lvl(lvl_reg),
    .found(pick_found),
    .idx(pick_idx),
    .lvl_out(pick_lvl)
  );

  always @*
  begin
    take_mask = {NUM_REQ{1'b0}};
    nm_take = {`NM_COUNT{1'b0}};
    take_any = 1'b0;
    take_mask_ev = 1'b0;
    take_num = 6'h00;
    if (instr_retire && !first_block_reg)
    begin
      take_any = 1'b1;
      if (nm_pend_reg[`NM_NMI])
      begin
        nm_take[`NM_NMI] = 1'b1;
        take_num = `NUM_NMI;
      end
      else if (nm_pend_reg[`NM_DBG])
      begin
        nm_take[`NM_DBG] = 1'b1;
        take_num = `NUM_DBG;
      end
      else if (nm_pend_reg[`NM_WDT])
      begin
        nm_take[`NM_WDT] = 1'b1;
        take_num = `NUM_WDT;
      end
      else if (ien_reg && pick_found && (pick_lvl > ipl_reg))
      begin
        take_mask[pick_idx] = 1'b1;
        take_mask_ev = 1'b1;
        take_num = {{(6-IDX_W){1'b0}}, pick_idx};
      end
      else if (nm_pend_reg[`NM_STEP])
      begin
        nm_take[`NM_STEP] = 1'b1;
        take_num = `NUM_STEP;
      end
      else if (nm_pend_reg[`NM_MATCH])
      begin
        nm_take[`NM_MATCH] = 1'b1;
        take_num = `NUM_MATCH;
      end
      else
        take_any = 1'b0;
    end
  end

  // Enable flag and processor level next values
  always @*
  begin
    ien_next = ien_reg;
    ipl_next = ipl_reg;
    if (wr_fire && (addr_reg == `OFS_CTRL))
    begin
      ien_next = hwdata[`CTRL_IEN_BIT];
      ipl_next = hwdata[`CTRL_IPL_MSB:`CTRL_IPL_LSB];
    end
    if (reti_valid)
    begin
      ien_next = reti_ien;
      ipl_next = reti_level;
    end
    if (take_any)
    begin
      ien_next = 1'b0;
      if (take_mask_ev)
        ipl_next = pick_lvl;
      else if (nm_take[`NM_NMI] || nm_take[`NM_WDT])
        ipl_next = `LVL_TOP;
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ien_reg <= 1'b0;
      ipl_reg <= `RST_IPL;
      first_block_reg <= 1'b1;
      accept_valid <= 1'b0;
      accept_number <= 6'h00;
    end
    else
    begin
      ien_reg <= ien_next;
      ipl_reg <= ipl_next;
      accept_valid <= take_any;
      if (instr_retire)
        first_block_reg <= 1'b0;
      if (take_any)
        accept_number <= take_num;
    end
  end

  // ----------------------------------------------------------------
  // Request control words
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_REQ; g = g + 1)
    begin : g_req
      wire wr_me;
      wire info_me;
      assign wr_me = wr_fire && req_hit && (req_sel == g);
      assign info_me = info_read && pick_found && (pick_idx == g);
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          pend_reg[g] <= 1'b0;
          lvl_reg[3*g +: 3] <= 3'h0;
        end
        else
        begin
          if (wr_me)
            lvl_reg[3*g +: 3] <= hwdata[`REQ_LVL_MSB:0];
          // new request wins over any clear
          if (req_s2_reg[g] && !req_s3_reg[g])
            pend_reg[g] <= 1'b1;
          else if (take_mask[g] || info_me)
            pend_reg[g] <= 1'b0;
          else if (wr_me && !hwdata[`REQ_PEND_BIT])
            pend_reg[g] <= 1'b0;
        end
      end
    end
    for (g = 0; g < `NM_COUNT; g = g + 1)
    begin : g_nm
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          nm_pend_reg[g] <= 1'b0;
        else if (nm_s2_reg[g] && !nm_s3_reg[g])
          nm_pend_reg[g] <= 1'b1;
        else if (nm_take[g])
          nm_pend_reg[g] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Stack pointers and event status
  // ----------------------------------------------------------------
  assign ev_set = {info_read, take_any & ~take_mask_ev, take_mask_ev};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      user_stack_pointer <= `RST_SP;
      handler_stack_pointer <= `RST_SP;
      en_reg <= {`EV_COUNT{1'b0}};
      stat_reg <= {`EV_COUNT{1'b0}};
    end
    else
    begin
      if (wr_fire && (addr_reg == `OFS_USP))
        user_stack_pointer <= hwdata[15:0];
      if (wr_fire && (addr_reg == `OFS_ISP))
        handler_stack_pointer <= hwdata[15:0];
      if (wr_fire && (addr_reg == `OFS_EN))
        en_reg <= hwdata[`EV_COUNT-1:0];
      // Set beats a simultaneous clear
      if (wr_fire && (addr_reg == `OFS_CLR))
        stat_reg <= (stat_reg & ~hwdata[`EV_COUNT-1:0]) | ev_set;
      else
        stat_reg <= stat_reg | ev_set;
    end
  end
endmodule // nested_interrupt_acceptance
`default_nettype wire

// ---- logic/nia_defs.vh ----
// Offsets, field positions, reset values and codes of the interrupt acceptance block
`ifndef NIA_DEFS_VH
`define NIA_DEFS_VH
`define OFS_INFO 8'h00
`define OFS_CTRL 8'h04
`define OFS_USP 8'h08
`define OFS_ISP 8'h0C
`define OFS_REQ_BASE 8'h10
`define OFS_STAT 8'h40
`define OFS_CLR 8'h44
`define OFS_EN 8'h48
`define CTRL_IEN_BIT 0
`define CTRL_IPL_LSB 4
`define CTRL_IPL_MSB 6
`define REQ_LVL_MSB 2
`define REQ_PEND_BIT 3
`define RST_IPL 3'h0
`define RST_SP 16'h0000
`define LVL_TOP 3'h7
`define NM_NMI 0
`define NM_DBG 1
`define NM_WDT 2
`define NM_STEP 3
`define NM_MATCH 4
`define NM_COUNT 5
`define NUM_NMI 6'h3A
`define NUM_DBG 6'h3B
`define NUM_WDT 6'h3C
`define NUM_STEP 6'h3D
`define NUM_MATCH 6'h3E
`define EV_MASKABLE 0
`define EV_NONMASK 1
`define EV_INFO_READ 2
`define EV_COUNT 3
`endif

// ---- logic/request_pick.v ----
// Selector of the highest-level enabled pending maskable request
`timescale 1ns/1ps
`default_nettype none
module request_pick #(
  parameter NUM_REQ = 8,
  parameter IDX_W = 3
) (
  input wire [NUM_REQ-1:0] pend, // Pending bits
  input wire [3*NUM_REQ-1:0] lvl, // Programmed levels, three bits each
  output reg found, // Some enabled request is pending
  output reg [IDX_W-1:0] idx, // Chosen request number
  output reg [2:0] lvl_out // Level of the chosen request
);
  integer i;
  // Strictly greater keeps the lowest number on a tie of levels
  always @*
  begin
    found = 1'b0;
    idx = {IDX_W{1'b0}};
    lvl_out = 3'h0;
    for (i = 0; i < NUM_REQ; i = i + 1)
    begin
      if (pend[i] && (lvl[3*i +: 3] > lvl_out))
      begin
        found = 1'b1;
        idx = i[IDX_W-1:0];
        lvl_out = lvl[3*i +: 3];
      end
    end
  end
endmodule // request_pick
`default_nettype wire

// ---- testbench/core_side_model.sv ----
// Request sources and executing core on the far side
`timescale 1ns/1ps
`default_nettype none
`include "nia_defs.vh"
module core_side_model #(
  parameter NUM_REQ = 8
) (
  input wire logic hclk, // Core clock
  output logic [NUM_REQ-1:0] req_in, // Peripheral requests
  output logic [`NM_COUNT-1:0] nm_in, // Non-maskable requests
  output logic instr_retire, // Boundary pulse
  output logic reti_valid, // Return pulse
  output logic [2:0] reti_level, // Restored level
  output logic reti_ien // Restored enable
);
  // Idle sources and core at time zero
  initial
  begin
    req_in = '0;
    nm_in = '0;
    instr_retire = 1'h0;
    reti_valid = 1'h0;
    reti_level = 3'h0;
    reti_ien = 1'h0;
  end
  // One instruction boundary
  task automatic retire();
    @(posedge hclk) instr_retire <= 1'h1;
    @(posedge hclk) instr_retire <= 1'h0;
  endtask
  task automatic ret(input logic [2:0] l, input logic e);
    @(posedge hclk);
    reti_valid <= 1'h1;
    reti_level <= l;
    reti_ien <= e;
    @(posedge hclk);
    reti_valid <= 1'h0;
    reti_level <= ~l; // Meaningless outside the pulse
    reti_ien <= ~e;
  endtask
  // Raise sources long enough to pass the synchroniser, then drop them
  task automatic pulse(input logic [NUM_REQ-1:0] r, input logic [`NM_COUNT-1:0] n);
    @(posedge hclk);
    req_in <= r;
    nm_in <= n;
    repeat (6) @(posedge hclk);
    req_in <= '0;
    nm_in <= '0;
    repeat (4) @(posedge hclk);
  endtask
endmodule // core_side_model
`default_nettype wire

// ---- testbench/nia_checker_sva.sv ----
// Port checker for the interrupt acceptance block
`timescale 1ns/1ps
`default_nettype none
`include "nia_defs.vh"
module nia_checker #(
  parameter NUM_REQ = 8
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic instr_retire, // Boundary
  input wire logic accept_valid, // Entry pulse
  input wire logic [5:0] accept_number, // Entry number
  input wire logic [2:0] processor_priority_level, // Level
  input wire logic global_enable // Enable flag
);
  logic seen_reg; // A boundary has passed since reset
  wire logic take = hsel && htrans[1] && hready; // Address phase taken
  // Remember the first boundary after reset
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      seen_reg <= 1'h0;
    else if (instr_retire)
      seen_reg <= 1'h1;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_first_blocked: assert property (
    instr_retire && !seen_reg |=> !accept_valid) else $error("entry on first boundary");
  a_entry_disables: assert property (
    accept_valid |-> !global_enable) else $error("enable kept on entry");
  a_entry_boundary: assert property (
    accept_valid |-> $past(instr_retire)) else $error("entry off boundary");
  a_mask_above: assert property (
    accept_valid && accept_number < NUM_REQ |-> $past(global_enable)
    && processor_priority_level > $past(processor_priority_level)) else $error("low entry");
  a_nm_top: assert property (
    accept_valid && (accept_number == `NUM_NMI || accept_number == `NUM_WDT)
    |-> processor_priority_level == `LVL_TOP) else $error("level not top");
  a_dbg_keeps: assert property (
    accept_valid && accept_number == `NUM_DBG |-> $stable(processor_priority_level))
    else $error("debug entry moved level");
  a_read_wait: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_fast: assert property (
    take && hwrite |=> hreadyout) else $error("write stalled");
  a_resp_okay: assert property (!hresp) else $error("error response");
  cover property (accept_valid && accept_number < NUM_REQ);
  cover property (accept_valid && accept_number == `NUM_DBG);
  cover property (take && !hwrite);
endmodule // nia_checker
bind nested_interrupt_acceptance nia_checker #(.NUM_REQ(NUM_REQ)) nia_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .instr_retire(instr_retire),
  .accept_valid(accept_valid), .accept_number(accept_number),
  .processor_priority_level(processor_priority_level), .global_enable(global_enable));
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench of the interrupt acceptance block
`timescale 1ns/1ps
`default_nettype none
`include "nia_defs.vh"
module tb_top;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [15:0] seed;
  logic [2:0] i, l, p;
  logic [7:0] ra;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  wire logic hreadyout, hresp, instr_retire, reti_valid, reti_ien;
  wire logic accept_valid, global_enable, irq;
  wire logic [31:0] hrdata;
  wire logic [7:0] req_in;
  wire logic [`NM_COUNT-1:0] nm_in;
  wire logic [2:0] reti_level, processor_priority_level;
  wire logic [5:0] accept_number;
  nested_interrupt_acceptance nested_interrupt_acceptance_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .req_in(req_in), .nm_in(nm_in),
    .instr_retire(instr_retire), .reti_valid(reti_valid), .reti_level(reti_level),
    .reti_ien(reti_ien), .accept_valid(accept_valid), .accept_number(accept_number),
    .processor_priority_level(processor_priority_level),
    .global_enable(global_enable), .irq(irq));
  core_side_model core_side_model_inst (.hclk(hclk), .req_in(req_in), .nm_in(nm_in),
    .instr_retire(instr_retire), .reti_valid(reti_valid), .reti_level(reti_level),
    .reti_ien(reti_ien));
  // Clock and hang guard
  always #2.5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One single word transfer, waiting on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
    #1;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    check(n, rd, e);
  endtask
  // Pass one boundary and compare the entry
  task automatic acc(input logic v, input logic [5:0] num, input logic [2:0] lvl);
    core_side_model_inst.retire();
    #1;
    check("accept", accept_valid, v);
    if (v)
    begin
      check("number", accept_number, num);
      check("level", processor_priority_level, lvl);
      check("enable", global_enable, 1'h0);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    rchk("usp", `OFS_USP, 32'h0);
    rchk("isp", `OFS_ISP, 32'h0);
    bus(1'h1, `OFS_ISP, 32'h1234);
    core_side_model_inst.pulse(8'h0, 5'h1);
    acc(1'h0, 6'h0, 3'h0);
    acc(1'h1, `NUM_NMI, 3'h7);
    core_side_model_inst.ret(3'h0, 1'h1);
    seed = 16'h6F64;
    repeat (16)
    begin
      seed = lfsr(seed);
      i = seed[2:0];
      l = seed[6:4];
      p = seed[10:8];
      ra = `OFS_REQ_BASE + {3'h0, i, 2'h0};
      // rewritten while no request is in flight
      bus(1'h1, ra, {29'h0, l});
      bus(1'h1, `OFS_CTRL, {25'h0, p, 4'h1});
      core_side_model_inst.pulse(8'h1 << i, 5'h0);
      acc(l > p, {3'h0, i}, l);
      rchk("pending", ra, {28'h0, !(l > p), l});
      bus(1'h1, ra, 32'h0);
    end
    bus(1'h1, 8'h1C, 32'h3);
    bus(1'h1, `OFS_CTRL, 32'h51);
    core_side_model_inst.pulse(8'h8, 5'h0);
    acc(1'h0, 6'h0, 3'h0);
    core_side_model_inst.ret(3'h3, 1'h1);
    acc(1'h0, 6'h0, 3'h0);
    core_side_model_inst.ret(3'h2, 1'h1);
    acc(1'h1, 6'h3, 3'h3);
    bus(1'h1, 8'h14, 32'h4);
    bus(1'h1, 8'h24, 32'h4);
    core_side_model_inst.ret(3'h0, 1'h1);
    core_side_model_inst.pulse(8'h22, 5'h2);
    acc(1'h1, `NUM_DBG, 3'h0);
    core_side_model_inst.ret(3'h0, 1'h1);
    acc(1'h1, 6'h1, 3'h4);
    core_side_model_inst.ret(3'h0, 1'h1);
    acc(1'h1, 6'h5, 3'h4);
    bus(1'h1, 8'h18, 32'h5);
    bus(1'h1, 8'h28, 32'h2);
    core_side_model_inst.pulse(8'h44, 5'h0);
    bus(1'h1, `OFS_EN, 32'h4);
    rchk("info", `OFS_INFO, 32'h142);
    rchk("req2", 8'h18, 32'h5);
    rchk("req6", 8'h28, 32'hA);
    check("irq", irq, 1'h1);
    bus(1'h1, `OFS_EN, 32'h0);
    check("irq masked", irq, 1'h0);
    bus(1'h1, `OFS_EN, 32'h4);
    bus(1'h1, `OFS_CLR, 32'h4);
    check("irq cleared", irq, 1'h0);
    rchk("status", `OFS_STAT, 32'h3);
    rchk("unmapped", 8'h80, 32'h0);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
